// ===== rtl/bbf_pkg.sv
package bbf_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;
  localparam logic [7:0] CMD_WRITE_SETUP_ALT = 8'h10;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_IDENTIFY = 8'h90;

  // ----------------------------------------------------------------
  // Widths and bus timing
  // ----------------------------------------------------------------
  localparam int ADDR_W = 17;
  localparam int DATA_W = 16;
  localparam int CLK_PERIOD_NS = 100;
  localparam int WE_PULSE_NS = 200;
  localparam int READ_ACCESS_NS = 300;
  localparam int WE_PULSE_CYC = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_ACCESS_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;

  typedef enum logic [2:0] {
    BBF_OP_READ,
    BBF_OP_PROGRAM,
    BBF_OP_ERASE,
    BBF_OP_READ_ARRAY,
    BBF_OP_IDENTIFY,
    BBF_OP_READ_ID
  } bbf_op_t;

  typedef struct packed {
    bbf_op_t op;
    logic boot_block;
    logic byte_mode;
    logic [ADDR_W-1:0] addr;
    logic addr_lsb;
    logic [DATA_W-1:0] data;
  } bbf_req_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic wp;
    logic byte_n;
    logic unlock_hv;
    logic id_hv_a9;
    logic [ADDR_W-1:0] addr;
  } bbf_pins_t;

endpackage

// ===== rtl/bbf_host.sv
// Functional notes
// R1: Erase sends setup code then confirm code, back to back.
// R2: Program sends a write setup then the address and data cycle.
// R3: Read-array command issued after program or erase before array reads.
// R4: Boot block writes raise write-protect high or the unlock voltage.
// R5: Other blocks are written with reset pin normally high.
// R6: Identification reads use address bit 0 and high voltage on A9.
// R7: Word-mode identification reads return the upper byte too.
// R8: Identify command offered as alternative to A9 high voltage.
// R9: Byte mode puts the address lsb on data line 15.
// R10: Device algorithms run alone; host only issues commands.
// R11: Erase targets one block only.
// R12: Read samples data while write enable high, chip and output enables low.
// R13: Device reset pin held low during host reset.
// R14: Byte mode leaves data lines 8 to 14 undriven.
// R15: Chip enable high between cycles keeps the device in standby; host holds it low through the gap between program or erase cycles.
module bbf_host (
  ref_clk,
  reset_n,
  clk_en,
  req_valid,
  req_ready,
  req,
  rsp_valid,
  rsp_data,
  pins,
  reset_powerdown_n,
  dq_in,
  dq_out,
  dq_oe
);
  import bbf_pkg::*;
  input wire logic ref_clk;
  input wire logic reset_n;
  input wire logic clk_en;
  input wire logic req_valid;
  output logic req_ready;
  input wire bbf_pkg::bbf_req_t req;
  output logic rsp_valid;
  output logic [bbf_pkg::DATA_W-1:0] rsp_data;
  output bbf_pkg::bbf_pins_t pins;
  output logic reset_powerdown_n;
  input wire logic [bbf_pkg::DATA_W-1:0] dq_in;
  output logic [bbf_pkg::DATA_W-1:0] dq_out;
  output logic [bbf_pkg::DATA_W-1:0] dq_oe;

  typedef enum logic [2:0] {
    S_IDLE,
    S_WR_PULSE,
    S_WR_GAP,
    S_RD_WAIT,
    S_DONE
  } bbf_state_t;

  bbf_state_t state_q;
  bbf_req_t req_q;
  logic phase_q;
  logic [CNT_W-1:0] cnt_q;
  logic [DATA_W-1:0] dq_s1_q;
  logic [DATA_W-1:0] dq_s2_q;
  logic [DATA_W-1:0] rsp_data_q;
  logic rsp_valid_q;
  logic rst_pin_q;

  // ----------------------------------------------------------------
  // Cycle decode
  // ----------------------------------------------------------------
  function automatic logic two_cycle(input bbf_op_t op);
    two_cycle = (op == BBF_OP_PROGRAM) || (op == BBF_OP_ERASE);
  endfunction

  function automatic logic is_read(input bbf_op_t op);
    is_read = (op == BBF_OP_READ) || (op == BBF_OP_READ_ID);
  endfunction

  wire logic idle = (state_q == S_IDLE);
  wire logic writing = (state_q == S_WR_PULSE) || (state_q == S_WR_GAP);
  wire logic reading = (state_q == S_RD_WAIT);
  wire logic byte_m = req_q.byte_mode;
  wire logic second = phase_q;
  logic [7:0] cmd_byte;
  // R1 R2 R3 R8 command byte choice
  assign cmd_byte = (req_q.op == BBF_OP_ERASE) ? (second ? CMD_ERASE_CONFIRM : CMD_ERASE_SETUP) :
                    (req_q.op == BBF_OP_PROGRAM) ? CMD_WRITE_SETUP :
                    (req_q.op == BBF_OP_IDENTIFY) ? CMD_IDENTIFY : CMD_READ_ARRAY;
  wire logic data_cycle = second && (req_q.op == BBF_OP_PROGRAM);
  logic [DATA_W-1:0] wr_word;
  // R9 R14 byte mode uses low byte and line 15 as address
  assign wr_word = data_cycle ? (byte_m ? {req_q.addr_lsb, 7'h00, req_q.data[7:0]} : req_q.data) :
                   {byte_m ? req_q.addr_lsb : 1'b0, 7'h00, cmd_byte};
  // Word-mode command cycles leave the upper byte undriven
  wire logic [DATA_W-1:0] oe_mask = byte_m ? 16'h80ff : (data_cycle ? 16'hffff : 16'h00ff);
  // R9 read address lsb rides on line 15 in byte mode
  wire logic [DATA_W-1:0] rd_oe_mask = byte_m ? 16'h8000 : 16'h0000;
  // R4 R5 protection unlock only for boot block program or erase
  wire logic boot_unlock = req_q.boot_block && two_cycle(req_q.op) && !idle;
  wire logic pulse = (state_q == S_WR_PULSE);
  wire logic take = req_valid && req_ready;
  wire logic rd_req = is_read(req.op);
  wire logic cnt_last = (cnt_q <= CNT_W'(1));
  wire logic [CNT_W-1:0] cnt_next = cnt_q - CNT_W'(1);
  // Read wait loads READ_ACCESS_CYC alone; both synchroniser stages fall inside it, adding no latency
  wire logic [CNT_W-1:0] cnt_load = CNT_W'(rd_req ? READ_ACCESS_CYC : WE_PULSE_CYC);
  // R7 word mode keeps upper byte; byte mode masks it
  wire logic [DATA_W-1:0] rd_word = byte_m ? {8'h00, dq_s2_q[7:0]} : dq_s2_q;

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // R15 chip enable high outside cycles keeps device in standby
  // Chip enable spans the gap so write enable always rises first
  assign pins.ce_n = !(writing || reading);
  // R12 output enable only when write enable is high
  assign pins.oe_n = !reading;
  assign pins.we_n = !pulse;
  // R4 write-protect high for boot block
  assign pins.wp = boot_unlock;
  // Unlock voltage is never raised; boot access relies on write-protect
  assign pins.unlock_hv = 1'b0;
  assign pins.byte_n = !byte_m;
  // R6 high voltage on A9 for direct identification reads
  assign pins.id_hv_a9 = reading && (req_q.op == BBF_OP_READ_ID);
  assign pins.addr = req_q.addr;
  assign dq_out = wr_word;
  assign dq_oe = writing ? oe_mask : (reading ? rd_oe_mask : 16'h0000);
  // R13 reset pin held low during host reset
  assign reset_powerdown_n = rst_pin_q;
  // Ready waits for the reset pin to rise so the device is awake
  assign req_ready = idle && rst_pin_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_pin_q <= 1'b0;
      state_q <= S_IDLE;
      phase_q <= 1'b0;
      cnt_q <= '0;
      req_q <= '0;
      rsp_valid_q <= 1'b0;
      rsp_data_q <= '0;
    end
    else if (clk_en)
    begin
      rst_pin_q <= 1'b1;
      rsp_valid_q <= 1'b0;
      case (state_q)
        S_IDLE:
        begin
          if (take)
          begin
            req_q <= req;
            phase_q <= 1'b0;
            cnt_q <= cnt_load;
            state_q <= rd_req ? S_RD_WAIT : S_WR_PULSE;
          end
        end
        S_WR_PULSE:
        begin
          if (!cnt_last)
            cnt_q <= cnt_next;
          else
            state_q <= S_WR_GAP;
        end
        S_WR_GAP:
        begin
          // R1 R2 second cycle follows setup with nothing between
          if (two_cycle(req_q.op) && !phase_q)
          begin
            phase_q <= 1'b1;
            cnt_q <= CNT_W'(WE_PULSE_CYC);
            state_q <= S_WR_PULSE;
          end
          // R10 device runs the algorithm; host is done
          else
            state_q <= S_DONE;
        end
        S_RD_WAIT:
        begin
          if (!cnt_last)
            cnt_q <= cnt_next;
          else
          begin
            rsp_data_q <= rd_word;
            state_q <= S_DONE;
          end
        end
        S_DONE:
        begin
          // One-cycle response pulse; ready returns in the same cycle
          rsp_valid_q <= 1'b1;
          state_q <= S_IDLE;
        end
        default:
          state_q <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read capture
  // ----------------------------------------------------------------
  // Data pins come from the device, so two stages before use
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dq_s1_q <= '0;
      dq_s2_q <= '0;
    end
    else if (clk_en)
    begin
      dq_s1_q <= dq_in;
      dq_s2_q <= dq_s1_q;
    end
  end

endmodule

// ===== tb/bbf_host_properties.sv
module bbf_host_properties (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire bbf_pkg::bbf_req_t req,
  input wire logic rsp_valid,
  input wire bbf_pkg::bbf_pins_t pins,
  input wire logic reset_powerdown_n,
  input wire logic [15:0] dq_out,
  input wire logic [15:0] dq_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  import bbf_pkg::*;
  wire tk = clk_en && req_valid && req_ready;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_erase_pair: assert property (tk && req.op == BBF_OP_ERASE |=>
    (!pins.we_n && dq_out[7:0] == 8'h20) [*2] ##1 pins.we_n ##1 (!pins.we_n && dq_out[7:0] == 8'hd0) [*2])
    else $error("erase pair");
  a_prog_seq: assert property (tk && req.op == BBF_OP_PROGRAM |=>
    (!pins.we_n && dq_out[7:0] == 8'h40) [*2] ##1 pins.we_n ##5 rsp_valid) else $error("program seq");
  a_boot_unlock: assert property (tk && req.boot_block && req.op inside {BBF_OP_PROGRAM, BBF_OP_ERASE}
    |-> ##4 pins.wp) else $error("boot unlock");
  a_byte_lsb: assert property (tk && req.op == BBF_OP_PROGRAM && req.byte_mode |-> ##4
    (!pins.byte_n && dq_out[15] == $past(req.addr_lsb, 4) && dq_oe[14:8] == 7'h0)) else $error("byte lsb");
  a_read_cycle: assert property (tk && req.op == BBF_OP_READ |=>
    (!pins.ce_n && !pins.oe_n && pins.we_n && dq_oe[14:0] == 15'h0) [*3] ##1 1'b1 ##1 rsp_valid) else $error("read");
  a_read_no_drive: assert property (!pins.oe_n |-> pins.we_n && dq_oe[14:0] == 15'h0)
    else $error("read drive");
  a_freeze_hold: assert property (!clk_en |=> $stable(pins) && $stable(rsp_valid) && $stable(req_ready))
    else $error("freeze");
  a_standby_z: assert property (pins.ce_n |-> dq_oe == 16'h0) else $error("standby");
  a_reset_pin: assert property (!reset_powerdown_n |-> pins.ce_n && pins.we_n) else $error("reset pin");
  a_busy_refuse: assert property (tk |=> !req_ready) else $error("busy");
endmodule

// ===== tb/bbf_flash_model.sv
module bbf_flash_model import bbf_pkg::*; #(
  // Identification words are arbitrary
  parameter logic [15:0] MFR_ID = 16'h3ca5,
  parameter logic [15:0] DEV_ID = 16'h3c5c
) (
  input wire bbf_pkg::bbf_pins_t pins,
  input wire logic reset_powerdown_n,
  input wire logic [15:0] dq_out,
  output logic [15:0] dq_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [logic [17:0]];
  logic [2:0] mode = 3'h0;
  logic [15:0] q;
  wire rd = reset_powerdown_n && !pins.ce_n && !pins.oe_n && pins.we_n;
  wire [17:0] key = {pins.addr, !pins.byte_n && dq_out[15]};
  wire open_blk = pins.addr[16:13] != 4'h0 || pins.wp;
  always @(negedge reset_powerdown_n) mode = 3'h0;
  always @(posedge pins.we_n)
    if (reset_powerdown_n && !pins.ce_n)
      case (mode)
        3'h2: begin if (open_blk) mem[key] = pins.byte_n ? dq_out : {8'hff, dq_out[7:0]}; mode = 3'h4; end
        3'h3: begin if (dq_out[7:0] == 8'hd0 && open_blk) foreach (mem[k]) if (k[17:14] == pins.addr[16:13])
          mem[k] = 16'hffff; mode = 3'h4; end
        default: case (dq_out[7:0])
          8'h20: mode = 3'h3;
          8'h40, 8'h10: mode = 3'h2;
          8'h90: mode = 3'h1;
          8'hff: mode = 3'h0;
          default: ;
        endcase
      endcase
  always @*
    if (pins.id_hv_a9 || mode == 3'h1) q = pins.addr[0] ? DEV_ID : MFR_ID;
    else if (mode == 3'h0) q = mem.exists(key) ? mem[key] : 16'hffff;
    else q = 16'h0080;
  assign dq_in = rd ? q : ~q;
endmodule

// ===== tb/tb_top.sv
module tb_top import bbf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] MFR_ID = 16'h3ca5;
  localparam logic [15:0] DEV_ID = 16'h3c5c;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic req_valid = 1'b0;
  bbf_req_t req = '0;
  logic req_ready, rsp_valid, reset_powerdown_n;
  logic [15:0] rsp_data, dq_in, dq_out, dq_oe;
  bbf_pins_t pins;
  logic [16:0] exp_q[$];
  logic [15:0] w [3];
  logic lsb;
  int n_fail = 0;
  int samples_checked = 0;
  bbf_host i_dut (.*);
  bbf_flash_model #(.MFR_ID(MFR_ID), .DEV_ID(DEV_ID)) i_flash (.pins(pins),
    .reset_powerdown_n(reset_powerdown_n), .dq_out(dq_out), .dq_in(dq_in));
  initial forever #50 ref_clk = ~ref_clk;
  task automatic test_done();
    n_fail += exp_q.size();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp_word(logic [15:0] e, logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD rsp_data exp %h got %h", e, g);
    end
  endtask
  // Request held until a settled ready, then released one edge later
  task automatic op(bbf_op_t o, logic bb, logic bm, logic [16:0] a, logic [15:0] d, logic c, logic [15:0] e);
    req <= '{o, bb, bm, a, lsb, d};
    req_valid <= 1'b1;
    do @(negedge ref_clk); while (req_ready !== 1'b1 || clk_en !== 1'b1);
    @(posedge ref_clk);
    exp_q.push_back({c, e});
    req_valid <= 1'b0;
    @(posedge ref_clk);
  endtask
  always @(posedge ref_clk)
    if (reset_n && rsp_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        n_fail++;
        $display("BAD rsp_valid exp 0 got 1");
      end
      else
      begin
        if (exp_q[0][16]) cmp_word(exp_q[0][15:0], rsp_data);
        void'(exp_q.pop_front());
      end
    end
  initial
  begin
    void'($urandom(65));
    foreach (w[i]) w[i] = 16'($urandom);
    lsb = 1'($urandom);
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    op(BBF_OP_PROGRAM, 0, 0, 17'h04010, w[0], 0, 0);
    op(BBF_OP_PROGRAM, 1, 0, 17'h00020, w[1], 0, 0);
    op(BBF_OP_PROGRAM, 0, 0, 17'h06030, w[2], 0, 0);
    op(BBF_OP_READ_ARRAY, 0, 0, 0, 0, 0, 0);
    op(BBF_OP_READ, 0, 0, 17'h04010, 0, 1, w[0]);
    op(BBF_OP_READ, 0, 0, 17'h00020, 0, 1, w[1]);
    op(BBF_OP_ERASE, 0, 0, 17'h04000, 0, 0, 0);
    op(BBF_OP_READ_ARRAY, 0, 0, 0, 0, 0, 0);
    op(BBF_OP_READ, 0, 0, 17'h04010, 0, 1, 16'hffff);
    repeat (6) @(posedge ref_clk);
    clk_en <= 1'b0;
    fork
      begin
        repeat (2 + $urandom % 3) @(posedge ref_clk);
        clk_en <= 1'b1;
      end
    join_none
    op(BBF_OP_READ, 0, 0, 17'h06030, 0, 1, w[2]);
    op(BBF_OP_READ_ID, 0, 0, 17'h0, 0, 1, MFR_ID);
    op(BBF_OP_IDENTIFY, 0, 0, 0, 0, 0, 0);
    op(BBF_OP_READ, 0, 0, 17'h00001, 0, 1, DEV_ID);
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    op(BBF_OP_READ, 0, 0, 17'h06030, 0, 1, w[2]);
    op(BBF_OP_PROGRAM, 0, 1, 17'h08000, w[0], 0, 0);
    op(BBF_OP_READ_ARRAY, 0, 0, 0, 0, 0, 0);
    op(BBF_OP_READ, 0, 1, 17'h08000, 0, 1, {8'h00, w[0][7:0]});
    lsb = !lsb;
    op(BBF_OP_READ, 0, 1, 17'h08000, 0, 1, 16'h00ff);
    op(BBF_OP_ERASE, 1, 0, 17'h00000, 0, 0, 0);
    op(BBF_OP_READ_ARRAY, 0, 0, 0, 0, 0, 0);
    op(BBF_OP_READ, 0, 0, 17'h00020, 0, 1, 16'hffff);
    repeat (12) @(posedge ref_clk);
    test_done();
  end
  initial
  begin
    #300000;
    n_fail++;
    test_done();
  end
endmodule
bind bbf_host bbf_host_properties i_props (.*);
